// file: src/rdcfg_pkg.sv
// Shared constants, layouts and types of the re-driver configuration block
package rdcfg_pkg;
  // Clock period and receiver-detect charge time
  localparam int CLK_PERIOD_PS = 8000;
  localparam int DET_TIMEOUT_NS = 1000;
  // Least time, so round up to whole cycles
  localparam int DET_TIMEOUT_CYC = (DET_TIMEOUT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Cycles after reset release before straps are taken
  localparam int STRAP_SETTLE_CYC = 3;
  // Register byte offsets
  localparam logic [7:0] ADDR_SIG = 8'h00;
  localparam logic [7:0] ADDR_RXD = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_GRPA = 8'h0c;
  localparam logic [7:0] ADDR_GRPB = 8'h10;
  localparam logic [7:0] ADDR_INFO = 8'h14;
  // Control register bit positions
  localparam int CTRL_LB = 0;
  localparam int CTRL_RST = 1;
  localparam int CTRL_PD = 3;
  localparam int CTRL_DET = 4;
  localparam int CTRL_POL = 6;
  // Group select register field positions
  localparam int GRP_EQ = 0;
  localparam int GRP_SW = 3;
  localparam int GRP_EM = 5;
  // Info register: mode level position
  localparam int INFO_MODE = 8;
  // Values before straps are taken (pull-ups read as ones)
  localparam logic [10:0] CFG_RST = 11'h7ff;
  localparam logic LB_RST = 1'b1;
  localparam logic PD_RST = 1'b1;
  // Per-group settings; eq, swing and emph make eight select bits
  typedef struct packed {
    logic restart_n;
    logic det_en;
    logic pol;
    logic [2:0] emph;
    logic [1:0] swing;
    logic [2:0] eq;
  } rdcfg_grp_t;
  // Per-group data channel termination and drive controls
  typedef struct packed {
    logic in_term;
    logic tx_drive;
    logic weak_pu;
  } rdcfg_io_t;
  // All pins from outside the clock domain
  typedef struct packed {
    logic mode;
    logic pd_n;
    logic card_n;
    logic lb_n;
    logic [2:0] addr;
    logic [1:0] lvl;
    logic [1:0] load;
    rdcfg_grp_t [1:0] grp;
  } rdcfg_pin_t;
  // Receiver-detect states
  typedef enum logic [2:0] {
    DET_RESET = 3'b001,
    DET_WAIT = 3'b010,
    DET_DONE = 3'b100
  } rdcfg_det_t;
endpackage : rdcfg_pkg

// file: src/rdcfg_rxdet.sv
// Receiver-detect sequencer for one group of four channels
`timescale 1ns/1ps
module rdcfg_rxdet #(
  parameter int TIMEOUT_CYC = rdcfg_pkg::DET_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Gating and sense
  input wire logic run,
  input wire logic restart_n,
  input wire logic load_cmp,
  // Result
  output logic sensed_r,
  output logic charge_r
);
  initial if (TIMEOUT_CYC < 1 || TIMEOUT_CYC > 65535) $error("Bad detect timeout");
  rdcfg_pkg::rdcfg_det_t st_r, st_nxt; // Sequencer state
  logic [15:0] cnt_r, cnt_nxt; // Charge time counter
  logic sensed_nxt, charge_nxt;

  // Next state: held in reset while restart low or not allowed to run
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sensed_nxt = sensed_r;
    charge_nxt = charge_r;
    if (!run || !restart_n) begin
      st_nxt = rdcfg_pkg::DET_RESET;
      cnt_nxt = 16'h0000;
      sensed_nxt = 1'b0;
      charge_nxt = 1'b0;
    end else begin
      unique case (st_r)
        rdcfg_pkg::DET_RESET: begin
          // Restart released, weak pull-up on, start charging
          st_nxt = rdcfg_pkg::DET_WAIT;
          cnt_nxt = 16'h0000;
          charge_nxt = 1'b1;
        end
        rdcfg_pkg::DET_WAIT: begin
          if (cnt_r == 16'(TIMEOUT_CYC - 1)) begin
            // Pin level settled, a 50 ohm load pulled it down
            st_nxt = rdcfg_pkg::DET_DONE;
            sensed_nxt = load_cmp;
            charge_nxt = 1'b0;
          end else begin
            cnt_nxt = cnt_r + 16'h0001;
          end
        end
        rdcfg_pkg::DET_DONE: begin
          // Result holds until restart goes low or run drops
          st_nxt = rdcfg_pkg::DET_DONE;
        end
        default: st_nxt = rdcfg_pkg::DET_RESET;
      endcase
    end
  end

  // Register stage
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r <= rdcfg_pkg::DET_RESET;
      cnt_r <= 16'h0000;
      sensed_r <= 1'b0;
      charge_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sensed_r <= sensed_nxt;
      charge_r <= charge_nxt;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  property p_restart_hold;
    !restart_n |=> (st_r == rdcfg_pkg::DET_RESET) && !sensed_r;
  endproperty
  a_restart_hold: assert property (p_restart_hold) else $error("Detect not held in reset");
  property p_sense_result;
    (st_r == rdcfg_pkg::DET_WAIT) && run && restart_n && (cnt_r == 16'(TIMEOUT_CYC - 1))
      |=> sensed_r == $past(load_cmp);
  endproperty
  a_sense_result: assert property (p_sense_result) else $error("Load result wrong");
  c_detect_done: cover property (st_r == rdcfg_pkg::DET_WAIT ##1 sensed_r);
endmodule : rdcfg_rxdet

// file: src/rdcfg_top.sv
// Configuration and control register bank of a two-group serial re-driver
// Summary of operation
// - Mode high freezes config, refuses bus writes
// - Mode low lets bus writes reprogram config
// - Mode level is live, never latched
// - Straps captured once at power-on
// - Power-down low disables all channel I/O
// - Card present low enables channels
// - Restart low holds group detection reset
// - Load sensed high on 50 ohm load
// - Level detect follows channel zero signal
// - Polarity high de-emphasis, low pre-emphasis
// - Loopback low routes A receive to both
// - Per-group enable of receiver detection
// - Three-bit equalizer select per group
// - Two-bit swing select per group
// - Three-bit emphasis level per group
// - Address bits 0, 1, 4 from straps
// - Eight select bits per group
// - Register port with 32-bit data words
// - Detection runs only with card present
// - Byte 0 signal, byte 4 load status
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module rdcfg_top #(
  parameter logic [6:0] SLAVE_ADDR_BASE = 7'h20, // Arbitrary base value
  parameter int DET_CYC = rdcfg_pkg::DET_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // APB register port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Live control pins; loopback_n is only sampled with the straps
  input wire logic mode,
  input wire logic power_down_n,
  input wire logic card_present_n,
  input wire logic loopback_n,
  input wire logic detect_restart_n_a,
  input wire logic detect_restart_n_b,
  // Strap pins
  input wire logic load_detect_en_a,
  input wire logic load_detect_en_b,
  input wire logic emph_polarity_a,
  input wire logic emph_polarity_b,
  input wire logic [2:0] eq_select_a,
  input wire logic [2:0] eq_select_b,
  input wire logic [1:0] swing_select_a,
  input wire logic [1:0] swing_select_b,
  input wire logic [2:0] emph_level_a,
  input wire logic [2:0] emph_level_b,
  input wire logic addr_strap_0,
  input wire logic addr_strap_1,
  input wire logic addr_strap_4,
  // Analog comparators of channel zero
  input wire logic level_cmp_a,
  input wire logic level_cmp_b,
  input wire logic load_cmp_a,
  input wire logic load_cmp_b,
  // Status pins
  output logic level_detect_a,
  output logic level_detect_b,
  output logic load_sensed_a,
  output logic load_sensed_b,
  // Analog control
  output rdcfg_pkg::rdcfg_grp_t cfg_a,
  output rdcfg_pkg::rdcfg_grp_t cfg_b,
  output rdcfg_pkg::rdcfg_io_t io_a,
  output rdcfg_pkg::rdcfg_io_t io_b,
  output logic loopback_active,
  output logic [6:0] slave_addr
);
  initial if (DET_CYC < 1) $error("Detect timeout must be positive");

  rdcfg_pkg::rdcfg_pin_t pin_raw, sync1_r, pin_s; // Pin synchroniser
  rdcfg_pkg::rdcfg_grp_t [1:0] cfg_r, cfg_nxt; // Group configuration
  rdcfg_pkg::rdcfg_io_t [1:0] io_r, io_nxt; // Channel I/O control
  logic lb_r, lb_nxt; // Loopback, active low
  logic lbact_r, lbact_nxt; // Loopback flag pin, kept in its own flop
  logic pdr_r, pdr_nxt; // Power-down bit, active low
  logic [6:0] sa_r, sa_nxt; // Slave address
  logic [1:0] sc_r, sc_nxt; // Strap settle counter
  logic sdone_r, sdone_nxt; // Straps taken
  logic [1:0] lvl_r, lvl_nxt; // Level detect flops
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt;
  logic [1:0] sensed; // Detect results
  logic [1:0] charge; // Detect pull-up
  logic pd_ok; // Not powered down
  logic strap_take; // One-cycle capture
  logic setup; // APB setup phase
  logic acc_wr; // Completing write
  logic cfg_wr; // Accepted config write
  logic is_cfg; // Config offset

  // Gather all outside pins
  always_comb begin
    pin_raw.mode = mode;
    pin_raw.pd_n = power_down_n;
    pin_raw.card_n = card_present_n;
    pin_raw.lb_n = loopback_n;
    pin_raw.addr = {addr_strap_4, addr_strap_1, addr_strap_0};
    pin_raw.lvl = {level_cmp_b, level_cmp_a};
    pin_raw.load = {load_cmp_b, load_cmp_a};
    pin_raw.grp[0] = {detect_restart_n_a, load_detect_en_a, emph_polarity_a,
                      emph_level_a, swing_select_a, eq_select_a};
    pin_raw.grp[1] = {detect_restart_n_b, load_detect_en_b, emph_polarity_b,
                      emph_level_b, swing_select_b, eq_select_b};
  end

  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge clock) begin
    sync1_r <= pin_raw;
    pin_s <= sync1_r;
  end

  // Power state: pin low or register bit low powers down
  assign pd_ok = pin_s.pd_n && pdr_r;
  assign strap_take = !sdone_r && (sc_r == 2'(rdcfg_pkg::STRAP_SETTLE_CYC - 1));
  assign setup = psel && !penable;
  assign acc_wr = psel && penable && pready && pwrite;
  assign is_cfg = (paddr == rdcfg_pkg::ADDR_CTRL) || (paddr == rdcfg_pkg::ADDR_GRPA) ||
                  (paddr == rdcfg_pkg::ADDR_GRPB);
  // Mode read live on every write, never held
  assign cfg_wr = acc_wr && is_cfg && !pin_s.mode && sdone_r;

  // Configuration next values: straps once, then bus writes
  always_comb begin
    cfg_nxt = cfg_r;
    lb_nxt = lb_r;
    pdr_nxt = pdr_r;
    sa_nxt = sa_r;
    sc_nxt = sc_r;
    sdone_nxt = sdone_r;
    if (!sdone_r) begin
      sc_nxt = sc_r + 2'h1;
    end
    if (strap_take) begin
      // Startup values from the straps
      cfg_nxt = pin_s.grp;
      lb_nxt = pin_s.lb_n;
      pdr_nxt = pin_s.pd_n;
      sa_nxt = SLAVE_ADDR_BASE;
      sa_nxt[0] = pin_s.addr[0];
      sa_nxt[1] = pin_s.addr[1];
      sa_nxt[4] = pin_s.addr[2];
      sdone_nxt = 1'b1;
    end else if (cfg_wr) begin
      case (paddr)
        rdcfg_pkg::ADDR_CTRL: begin
          lb_nxt = pwdata[rdcfg_pkg::CTRL_LB];
          pdr_nxt = pwdata[rdcfg_pkg::CTRL_PD];
          for (int g = 0; g < 2; g++) begin
            cfg_nxt[g].restart_n = pwdata[rdcfg_pkg::CTRL_RST + g];
            cfg_nxt[g].det_en = pwdata[rdcfg_pkg::CTRL_DET + g];
            cfg_nxt[g].pol = pwdata[rdcfg_pkg::CTRL_POL + g];
          end
        end
        rdcfg_pkg::ADDR_GRPA: begin
          cfg_nxt[0].eq = pwdata[rdcfg_pkg::GRP_EQ +: 3];
          cfg_nxt[0].swing = pwdata[rdcfg_pkg::GRP_SW +: 2];
          cfg_nxt[0].emph = pwdata[rdcfg_pkg::GRP_EM +: 3];
        end
        default: begin
          // Only group B is left among config offsets
          cfg_nxt[1].eq = pwdata[rdcfg_pkg::GRP_EQ +: 3];
          cfg_nxt[1].swing = pwdata[rdcfg_pkg::GRP_SW +: 2];
          cfg_nxt[1].emph = pwdata[rdcfg_pkg::GRP_EM +: 3];
        end
      endcase
    end
    lbact_nxt = !lb_nxt;
  end

  // Configuration registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cfg_r <= {2{rdcfg_pkg::CFG_RST}};
      lb_r <= rdcfg_pkg::LB_RST;
      lbact_r <= !rdcfg_pkg::LB_RST;
      pdr_r <= rdcfg_pkg::PD_RST;
      sa_r <= 7'h00;
      sc_r <= 2'h0;
      sdone_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      lb_r <= lb_nxt;
      lbact_r <= lbact_nxt;
      pdr_r <= pdr_nxt;
      sa_r <= sa_nxt;
      sc_r <= sc_nxt;
      sdone_r <= sdone_nxt;
    end
  end

  // One receiver-detect sequencer per group
  for (genvar g = 0; g < 2; g++) begin : g_det
    rdcfg_rxdet #(.TIMEOUT_CYC(DET_CYC)) u_det (
      .clock(clock),
      .sys_rst(sys_rst),
      // Allowed only powered, card present and enabled
      .run(pd_ok && !pin_s.card_n && cfg_r[g].det_en),
      .restart_n(pin_s.grp[g].restart_n && cfg_r[g].restart_n),
      .load_cmp(pin_s.load[g]),
      .sensed_r(sensed[g]),
      .charge_r(charge[g])
    );
  end

  // Channel I/O next values per group
  always_comb begin
    io_nxt = io_r;
    lvl_nxt = pin_s.lvl;
    for (int g = 0; g < 2; g++) begin
      logic src; // Receive level feeding this group's transmit
      logic rst_n; // Effective detect restart
      src = (g == 1 && !lb_r) ? pin_s.lvl[0] : pin_s.lvl[g];
      rst_n = pin_s.grp[g].restart_n && cfg_r[g].restart_n;
      if (!pd_ok || pin_s.card_n) begin
        // Powered down or no card: everything high impedance
        io_nxt[g] = 3'b000;
      end else if (!rst_n) begin
        io_nxt[g] = 3'b001;
      end else if (!cfg_r[g].det_en || sensed[g]) begin
        // Enabled: drive only with a valid input level
        io_nxt[g].in_term = 1'b1;
        io_nxt[g].tx_drive = src;
        io_nxt[g].weak_pu = !src;
      end else begin
        // Detection pending or no load: pull-up only
        io_nxt[g].in_term = 1'b0;
        io_nxt[g].tx_drive = 1'b0;
        io_nxt[g].weak_pu = 1'b1 || charge[g];
      end
    end
  end

  // Channel I/O registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      io_r <= '0;
      lvl_r <= 2'b00;
    end else begin
      io_r <= io_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  // APB next values: decode in setup, answer in access
  always_comb begin
    prdata_nxt = prdata;
    pslverr_nxt = 1'b0;
    pready_nxt = setup && !pready;
    if (setup) begin
      prdata_nxt = 32'h0000_0000;
      case (paddr)
        rdcfg_pkg::ADDR_SIG: begin
          prdata_nxt[1:0] = lvl_r;
          pslverr_nxt = pwrite;
        end
        rdcfg_pkg::ADDR_RXD: begin
          prdata_nxt[1:0] = sensed;
          pslverr_nxt = pwrite;
        end
        rdcfg_pkg::ADDR_CTRL: begin
          prdata_nxt[rdcfg_pkg::CTRL_LB] = lb_r;
          prdata_nxt[rdcfg_pkg::CTRL_PD] = pdr_r;
          for (int g = 0; g < 2; g++) begin
            prdata_nxt[rdcfg_pkg::CTRL_RST + g] = cfg_r[g].restart_n;
            prdata_nxt[rdcfg_pkg::CTRL_DET + g] = cfg_r[g].det_en;
            prdata_nxt[rdcfg_pkg::CTRL_POL + g] = cfg_r[g].pol;
          end
          pslverr_nxt = pwrite && (pin_s.mode || !sdone_r);
        end
        rdcfg_pkg::ADDR_GRPA, rdcfg_pkg::ADDR_GRPB: begin
          prdata_nxt[7:0] = cfg_r[paddr == rdcfg_pkg::ADDR_GRPB][7:0];
          pslverr_nxt = pwrite && (pin_s.mode || !sdone_r);
        end
        rdcfg_pkg::ADDR_INFO: begin
          prdata_nxt[6:0] = sa_r;
          prdata_nxt[rdcfg_pkg::INFO_MODE] = pin_s.mode;
          pslverr_nxt = pwrite;
        end
        default: pslverr_nxt = 1'b1;
      endcase
    end
  end

  // APB answer registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
    end
  end

  // Outputs straight from flops
  assign cfg_a = cfg_r[0];
  assign cfg_b = cfg_r[1];
  assign io_a = io_r[0];
  assign io_b = io_r[1];
  assign loopback_active = lbact_r;
  assign slave_addr = sa_r;
  assign level_detect_a = lvl_r[0];
  assign level_detect_b = lvl_r[1];
  assign load_sensed_a = sensed[0];
  assign load_sensed_b = sensed[1];

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  property p_mode_lock;
    acc_wr && is_cfg && pin_s.mode && sdone_r
      |=> $stable(cfg_r) && $stable(lb_r) && $stable(pdr_r);
  endproperty
  a_mode_lock: assert property (p_mode_lock) else $error("Write changed frozen config");
  property p_wr_grpa;
    acc_wr && (paddr == rdcfg_pkg::ADDR_GRPA) && !pin_s.mode && sdone_r
      |=> cfg_r[0][7:0] == $past(pwdata[7:0]);
  endproperty
  a_wr_grpa: assert property (p_wr_grpa) else $error("Group A write lost");
  property p_mode_live;
    setup && pwrite && (paddr == rdcfg_pkg::ADDR_GRPB) && sdone_r |=> pslverr == $past(pin_s.mode);
  endproperty
  a_mode_live: assert property (p_mode_live) else $error("Mode gating wrong");
  property p_strap;
    strap_take |=> cfg_r == $past(pin_s.grp) && lb_r == $past(pin_s.lb_n) && sdone_r;
  endproperty
  a_strap: assert property (p_strap) else $error("Straps not captured");
  property p_pd;
    !pd_ok |=> io_r == '0;
  endproperty
  a_pd: assert property (p_pd) else $error("Channels active in power-down");
  property p_card;
    pin_s.card_n ##1 pin_s.card_n |-> io_r == '0 && !sensed[0] && !sensed[1];
  endproperty
  a_card: assert property (p_card) else $error("Active without card");
  property p_level;
    ##1 lvl_r == $past(pin_s.lvl);
  endproperty
  a_level: assert property (p_level) else $error("Level detect stale");
  property p_loopback;
    !lb_r && pd_ok && !pin_s.card_n && io_nxt[1].in_term |=> io_r[1].tx_drive == $past(pin_s.lvl[0]);
  endproperty
  a_loopback: assert property (p_loopback) else $error("Loopback path wrong");
  property p_sig_read;
    setup && !pwrite && (paddr == rdcfg_pkg::ADDR_SIG) |=> prdata[1:0] == $past(lvl_r) && pready;
  endproperty
  a_sig_read: assert property (p_sig_read) else $error("Signal status read wrong");
  c_cfg_write: cover property (cfg_wr);
  c_refused: cover property (acc_wr && is_cfg && pin_s.mode);
  c_loopback: cover property (!lb_r && io_r[1].tx_drive);
endmodule : rdcfg_top

// file: testbench/rdcfg_board.sv
// Board-side model: card-present pin and channel-zero analog comparators
`timescale 1ns/1ps
module rdcfg_board (
  // Clock
  input wire logic clock,
  // Commands from the bench
  input wire logic card_in,
  input wire logic [1:0] sig_in,
  input wire logic [1:0] load_in,
  // Board pins
  output logic card_present_n,
  output logic [1:0] level_cmp,
  output logic [1:0] load_cmp
);
  // Pins move just after an edge; the block must resync them anyway
  always_ff @(posedge clock) begin
    card_present_n <= ~card_in; // Held low while a card sits
    level_cmp <= sig_in; // Lane zero above threshold
    load_cmp <= load_in; // High only with a 50 ohm far load
  end
endmodule : rdcfg_board

// file: testbench/rdcfg_top_tb_top.sv
// Self-checking bench of the re-driver configuration block
`timescale 1ns/1ps
module rdcfg_top_tb_top;
  // Expected bus reply
  typedef struct packed {logic rd; logic err; logic [31:0] d;} rdcfg_exp_t;
  localparam logic [6:0] SA_BASE = 7'h20; // Arbitrary base value
  localparam int DCYC = 4; // Short charge time keeps the run brief
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, wv, ga;
  logic pready, pslverr, loopback_active, card_present_n;
  logic mode = 1'b1, power_down_n = 1'b1, loopback_n = 1'b1;
  logic detect_restart_n_a = 1'b1, detect_restart_n_b = 1'b1;
  logic load_detect_en_a = 1'b1, load_detect_en_b = 1'b1;
  logic emph_polarity_a = 1'b1, emph_polarity_b = 1'b1;
  logic [2:0] eq_select_a = 3'h0, eq_select_b = 3'h0;
  logic [2:0] emph_level_a = 3'h0, emph_level_b = 3'h0;
  logic [1:0] swing_select_a = 2'h0, swing_select_b = 2'h0;
  logic addr_strap_0 = 1'b0, addr_strap_1 = 1'b0, addr_strap_4 = 1'b0;
  logic card_in = 1'b1;
  logic [1:0] sig_in = 2'h0, load_in = 2'h0, level_cmp, load_cmp;
  logic level_detect_a, level_detect_b, load_sensed_a, load_sensed_b;
  logic [6:0] slave_addr, sa;
  rdcfg_pkg::rdcfg_grp_t cfg_a, cfg_b;
  rdcfg_pkg::rdcfg_io_t io_a, io_b;
  rdcfg_exp_t exp_q[$]; // Replies still owed by the block
  int miscompares = 0, cmp_count = 0, cycles = 0;

  // Design and board
  rdcfg_top #(.SLAVE_ADDR_BASE(SA_BASE), .DET_CYC(DCYC)) rdcfg_top_i (
    .clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .mode, .power_down_n, .card_present_n, .loopback_n, .detect_restart_n_a,
    .detect_restart_n_b, .load_detect_en_a, .load_detect_en_b, .emph_polarity_a,
    .emph_polarity_b, .eq_select_a, .eq_select_b, .swing_select_a, .swing_select_b,
    .emph_level_a, .emph_level_b, .addr_strap_0, .addr_strap_1, .addr_strap_4,
    .level_cmp_a(level_cmp[0]), .level_cmp_b(level_cmp[1]), .load_cmp_a(load_cmp[0]),
    .load_cmp_b(load_cmp[1]), .level_detect_a, .level_detect_b, .load_sensed_a,
    .load_sensed_b, .cfg_a, .cfg_b, .io_a, .io_b, .loopback_active, .slave_addr);
  rdcfg_board rdcfg_board_i (.clock, .card_in, .sig_in, .load_in, .card_present_n,
    .level_cmp, .load_cmp);

  // 125 MHz clock
  always #4 clock = ~clock;

  // Closing report
  task automatic give_verdict();
    miscompares += exp_q.size(); // Replies that never came
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  // Bus reply compare
  task automatic chk_bus(input rdcfg_exp_t e);
    cmp_count++;
    if (pslverr !== e.err || (e.rd && prdata !== e.d)) begin
      miscompares++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, {e.err, e.d}, {pslverr, prdata});
    end
  endtask : chk_bus

  // Pin compare
  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk_pin

  // Idle cycles
  task automatic ticks(input int n);
    repeat (n) @(posedge clock);
  endtask : ticks

  // One APB transfer of a whole register word; the reply is noted for the monitor
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic e, input logic [31:0] x);
    exp_q.push_back('{rd: !w, err: e, d: x});
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Held until pready is seen high at an edge; only the hang guard ends a wait
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Monitor: each reply takes the oldest note
  always @(posedge clock) begin
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
      chk_bus(exp_q.pop_front());
    end
  end

  // Hang guard, far above the roughly 140 cycles needed
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      give_verdict();
    end
  end

  // Main sequence
  initial begin
    void'($urandom(32'h9f10));
    @(posedge clock);
    // Random straps, steady through reset and capture
    {eq_select_a, eq_select_b, emph_level_a, emph_level_b, swing_select_a,
      swing_select_b} <= 16'($urandom());
    {emph_polarity_a, emph_polarity_b, loopback_n, addr_strap_0, addr_strap_1,
      addr_strap_4} <= 6'($urandom());
    repeat (11) @(posedge clock);
    sys_rst <= 1'b0;
    ticks(8);
    ga = {24'h0, emph_level_a, swing_select_a, eq_select_a};
    sa = {SA_BASE[6:5], addr_strap_4, SA_BASE[3:2], addr_strap_1, addr_strap_0};
    // Startup values from straps
    apb(rdcfg_pkg::ADDR_CTRL, 1'b0, 32'h0, 1'b0,
      {24'h0, emph_polarity_b, emph_polarity_a, 5'h1f, loopback_n});
    apb(rdcfg_pkg::ADDR_GRPA, 1'b0, 32'h0, 1'b0, ga);
    apb(rdcfg_pkg::ADDR_GRPB, 1'b0, 32'h0, 1'b0,
      {24'h0, emph_level_b, swing_select_b, eq_select_b});
    apb(rdcfg_pkg::ADDR_INFO, 1'b0, 32'h0, 1'b0, {23'h0, 1'b1, 1'b0, sa});
    chk_pin({1'b0, slave_addr}, {1'b0, sa});
    chk_pin({7'h0, loopback_active}, {7'h0, ~loopback_n});
    // Mode high: writes refused, contents kept
    apb(rdcfg_pkg::ADDR_GRPA, 1'b1, 32'hff, 1'b1, 32'h0);
    apb(rdcfg_pkg::ADDR_GRPA, 1'b0, 32'h0, 1'b0, ga);
    // Mode low: bus reprograms, then high again freezes
    mode <= 1'b0;
    ticks(3);
    wv = $urandom();
    apb(rdcfg_pkg::ADDR_GRPB, 1'b1, wv, 1'b0, 32'h0);
    apb(rdcfg_pkg::ADDR_GRPB, 1'b0, 32'h0, 1'b0, {24'h0, wv[7:0]});
    chk_pin(cfg_b[7:0], wv[7:0]);
    apb(rdcfg_pkg::ADDR_GRPA, 1'b1, ~wv, 1'b0, 32'h0);
    // Control word: loopback on, restarts, power and detection kept on
    apb(rdcfg_pkg::ADDR_CTRL, 1'b1, {24'h0, wv[7:6], 6'h3e}, 1'b0, 32'h0);
    apb(rdcfg_pkg::ADDR_CTRL, 1'b0, 32'h0, 1'b0, {24'h0, wv[7:6], 6'h3e});
    chk_pin(cfg_a[7:0], ~wv[7:0]);
    chk_pin({7'h0, loopback_active}, 8'h01);
    apb(rdcfg_pkg::ADDR_INFO, 1'b0, 32'h0, 1'b0, {23'h0, 1'b0, 1'b0, sa});
    mode <= 1'b1;
    ticks(3);
    apb(rdcfg_pkg::ADDR_GRPB, 1'b1, ~wv, 1'b1, 32'h0);
    apb(rdcfg_pkg::ADDR_GRPB, 1'b0, 32'h0, 1'b0, {24'h0, wv[7:0]});
    apb(8'h3c, 1'b0, 32'h0, 1'b1, 32'h0); // Unmapped place
    apb(rdcfg_pkg::ADDR_SIG, 1'b1, 32'h3, 1'b1, 32'h0); // Status is read-only
    // Signal on lane A0 only
    sig_in <= 2'b01;
    ticks(8);
    chk_pin({6'h0, level_detect_b, level_detect_a}, 8'h01);
    apb(rdcfg_pkg::ADDR_SIG, 1'b0, 32'h0, 1'b0, 32'h1);
    // Detection held in reset, then run against a load
    detect_restart_n_a <= 1'b0;
    load_in <= 2'b11; // Group B keeps its old result until its next run
    ticks(8);
    chk_pin({4'h0, load_sensed_a, io_a}, 8'h01);
    detect_restart_n_a <= 1'b1;
    ticks(DCYC + 10);
    chk_pin({4'h0, load_sensed_a, io_a}, 8'h0e);
    apb(rdcfg_pkg::ADDR_RXD, 1'b0, 32'h0, 1'b0, 32'h1);
    // Power-down and card removal silence both groups
    power_down_n <= 1'b0;
    ticks(6);
    chk_pin({2'h0, io_b, io_a}, 8'h00);
    power_down_n <= 1'b1;
    card_in <= 1'b0;
    ticks(7);
    chk_pin({2'h0, io_b, io_a}, 8'h00);
    card_in <= 1'b1;
    ticks(DCYC + 12);
    chk_pin({4'h0, load_sensed_a, io_a}, 8'h0e);
    // Group B has no own signal, so it drives only through loopback
    chk_pin({4'h0, load_sensed_b, io_b}, 8'h0e);
    ticks(2);
    give_verdict();
  end
endmodule : rdcfg_top_tb_top
